// ===== rtl/ictr_pkg.sv
// Purpose: Shared constants and types for the interval counter channel
// Assumes: One 16-bit counter, binary or four-digit decimal counting
// Notes:   Mode codes follow the six counter modes
package ictr_pkg;

  // Counter width, top values and reset count
  localparam int          CNT_W   = 16;
  localparam logic [15:0] BIN_TOP = 16'hffff;
  localparam logic [15:0] BCD_TOP = 16'h9999;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Counting modes
  typedef enum logic [2:0] {
    M0 = 3'b000,
    M1 = 3'b001,
    M2 = 3'b010,
    M3 = 3'b011,
    M4 = 3'b100,
    M5 = 3'b101
  } mode_t;

  // Output level right after a control word
  localparam logic OUT_INIT_M0 = 1'b0;
  localparam logic OUT_INIT    = 1'b1;

  // Whole state of one channel
  typedef struct packed {
    logic [2:0]  clk_sync;
    logic [2:0]  gate_sync;
    logic        clk_st;
    logic        gate_st;
    mode_t       mode;
    logic        bcd;
    logic [15:0] init;
    logic [15:0] cnt;
    logic        out_lvl;
    logic        run;
    logic        load;
    logic        glvl;
    logic        eflag;
    logic        trig;
    logic        fired;
  } ictr_state_t;

endpackage : ictr_pkg

// ===== rtl/interval_counter.sv
// Purpose: One down-counter channel of a programmable interval timer
// Assumes: Counter clock and gate are pins, filtered on sys_clk
// Notes:   Overview of operation follows
// Overview of operation
// - Control word clears logic, sets output level
// - Gate sampled only at counter clock rise
// - Modes 0,2,3,4: gate level enables counting
// - Modes 1,2,3,5: gate rise sets trigger flag
// - Flag cleared after sampling; short pulses caught
// - Modes 2,3: gate rise restarts, level enables
// - Load and decrement only at clock fall
// - Initial count zero means largest count
// - Modes 0,1,4,5 wrap to top value
// - Modes 2,3 reload initial count themselves
// - Modes 2,3: gate low forces output high
// - Mode 2: output low one clock at one
// - Mode 1: trigger loads, output low next clock
`timescale 1ns/10ps
`default_nettype none
module interval_counter
  import ictr_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  // System
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Host programming strobes
  input  wire logic        cw_wr,
  input  wire logic [2:0]  cw_mode,
  input  wire logic        cw_bcd,
  input  wire logic        cnt_wr,
  input  wire logic [15:0] cnt_val,
  // Counter pins
  input  wire logic        ctr_clk,
  input  wire logic        gate,
  output      logic        out_level,
  // Status
  output      logic [15:0] count_now
);

  // Refuse widths the decimal logic cannot serve
  if (WIDTH != 16) begin : g_width_chk
    $error("interval_counter supports WIDTH 16 only");
  end

  ictr_state_t st;
  ictr_state_t next_st;

  // Subtract k from v in binary or packed decimal
  function automatic logic [15:0] sub_cnt(input logic [15:0] v,
                                          input logic [1:0]  k,
                                          input logic        bcd);
    logic [15:0] r;
    logic [4:0]  d;
    logic [1:0]  b;
    r = v - {14'h0000, k};
    b = k;
    if (bcd) begin
      for (int i = 0; i < 4; i++) begin
        d = {1'b0, v[i*4 +: 4]} - {3'b000, b};
        if (d[4]) begin
          r[i*4 +: 4] = d[3:0] + 4'ha;
          b = 2'b01;
        end else begin
          r[i*4 +: 4] = d[3:0];
          b = 2'b00;
        end
      end
    end
    return r;
  endfunction : sub_cnt

  logic        clk_new;
  logic        gate_new;
  logic        clk_rise;
  logic        clk_fall;
  logic        gate_rise;
  logic        edge_mode;
  logic        lvl_mode;
  logic        cnt_en;
  logic        do_load;
  logic [1:0]  step;
  logic [15:0] dec1;
  mode_t       wr_mode;

  // Filtered pin levels and edges
  always_comb begin
    clk_new   = (st.clk_sync[1] == st.clk_sync[2]) ? st.clk_sync[2] : st.clk_st;
    gate_new  = (st.gate_sync[1] == st.gate_sync[2]) ? st.gate_sync[2] : st.gate_st;
    clk_rise  = clk_new & ~st.clk_st;
    clk_fall  = ~clk_new & st.clk_st;
    gate_rise = gate_new & ~st.gate_st;
    edge_mode = (st.mode != M0) && (st.mode != M4);
    lvl_mode  = (st.mode != M1) && (st.mode != M5);
    cnt_en    = lvl_mode ? st.glvl : 1'b1;
    do_load   = st.load | (st.trig & edge_mode);
    dec1      = sub_cnt(st.cnt, 2'b01, st.bcd);
    if (!st.cnt[0]) begin
      step = 2'b10;
    end else begin
      step = st.out_lvl ? 2'b01 : 2'b11;
    end
    wr_mode = (cw_mode[2:1] == 2'b11) ? mode_t'({1'b0, cw_mode[1:0]})
                                      : mode_t'(cw_mode);
  end

  // Next state of the whole channel
  always_comb begin
    next_st           = st;
    next_st.clk_sync  = {st.clk_sync[1:0], ctr_clk};
    next_st.gate_sync = {st.gate_sync[1:0], gate};
    next_st.clk_st    = clk_new;
    next_st.gate_st   = gate_new;
    // Gate sampling at counter clock rise
    if (clk_rise) begin
      next_st.glvl  = st.gate_st;
      next_st.trig  = st.eflag & edge_mode;
      next_st.eflag = 1'b0;
    end
    if (gate_rise && edge_mode) begin
      next_st.eflag = 1'b1;
    end
    // Load and count at counter clock fall
    if (clk_fall) begin
      next_st.trig = 1'b0;
      if (do_load) begin
        next_st.cnt   = st.init;
        next_st.load  = 1'b0;
        next_st.run   = 1'b1;
        next_st.fired = 1'b0;
        if (st.mode == M1) begin
          next_st.out_lvl = 1'b0;
        end
        if (st.mode == M2 || st.mode == M3) begin
          next_st.out_lvl = 1'b1;
        end
      end else if (st.run && cnt_en) begin
        case (st.mode)
          M0, M1: begin
            next_st.cnt = dec1;
            if (st.cnt == 16'h0001) begin
              next_st.out_lvl = 1'b1;
            end
          end
          M4, M5: begin
            next_st.cnt     = dec1;
            next_st.out_lvl = 1'b1;
            if (st.cnt == 16'h0001 && !st.fired) begin
              next_st.out_lvl = 1'b0;
              next_st.fired   = 1'b1;
            end
          end
          M2: begin
            if (st.cnt == 16'h0001) begin
              next_st.cnt     = st.init;
              next_st.out_lvl = 1'b1;
            end else begin
              next_st.cnt = dec1;
              if (st.cnt == 16'h0002) begin
                next_st.out_lvl = 1'b0;
              end
            end
          end
          M3: begin
            if (st.cnt == {14'h0000, step}) begin
              next_st.cnt     = st.init;
              next_st.out_lvl = ~st.out_lvl;
            end else begin
              next_st.cnt = sub_cnt(st.cnt, step, st.bcd);
            end
          end
          default: begin
            next_st.cnt = st.cnt;
          end
        endcase
      end
    end
    // Initial count written by the host
    if (cnt_wr) begin
      next_st.init = cnt_val;
      case (st.mode)
        M0: begin
          next_st.load    = 1'b1;
          next_st.out_lvl = 1'b0;
        end
        M4: next_st.load = 1'b1;
        M2, M3: begin
          if (!st.run) begin
            next_st.load = 1'b1;
          end
        end
        default: next_st.load = st.load;
      endcase
    end
    // Gate low forces output high in periodic modes
    if ((st.mode == M2 || st.mode == M3) && !gate_new) begin
      next_st.out_lvl = 1'b1;
    end
    // Control word resets the control logic at once
    if (cw_wr) begin
      next_st.mode    = wr_mode;
      next_st.bcd     = cw_bcd;
      next_st.load    = 1'b0;
      next_st.run     = 1'b0;
      next_st.eflag   = 1'b0;
      next_st.trig    = 1'b0;
      next_st.fired   = 1'b0;
      next_st.out_lvl = (wr_mode == M0) ? OUT_INIT_M0 : OUT_INIT;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st         <= '0;
      st.cnt     <= CNT_RST;
      st.out_lvl <= OUT_INIT;
    end else begin
      st <= next_st;
    end
  end

  assign out_level = st.out_lvl;
  assign count_now = st.cnt;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_fall_run;
    clk_fall && st.run && !do_load && !cnt_wr && !cw_wr;
  endsequence

  a_cw_reset_out: assert property (cw_wr |=>
    !st.run && !st.load && (st.out_lvl == (st.mode != M0)))
    else $error("control word did not reset channel");
  a_gate_sample_edge: assert property ($changed(st.glvl) |->
    $past(clk_rise))
    else $error("gate level sampled off clock rise");
  a_gate_halts_cnt: assert property (s_fall_run ##0 (lvl_mode && !st.glvl)
    |=> $stable(st.cnt))
    else $error("count moved with gate low");
  a_edge_flag_set: assert property (gate_rise && edge_mode && !cw_wr
    |=> st.eflag)
    else $error("gate rise not captured");
  a_flag_cleared: assert property (clk_rise && !gate_rise && !cw_wr
    |=> !st.eflag && (st.trig == $past(st.eflag && edge_mode)))
    else $error("edge flag not moved to trigger");
  a_restart_trig: assert property ((st.mode == M2 || st.mode == M3)
    && st.trig && clk_fall && !cw_wr && !cnt_wr |=> st.cnt == st.init)
    else $error("trigger did not restart count");
  a_cnt_on_fall: assert property ($changed(st.cnt) |-> $past(clk_fall))
    else $error("count changed off clock fall");
  a_zero_wraps: assert property (s_fall_run ##0 (cnt_en && st.cnt == 16'h0000
    && (st.mode == M0 || st.mode == M1 || st.mode == M4 || st.mode == M5))
    |=> st.cnt == (st.bcd ? BCD_TOP : BIN_TOP))
    else $error("zero count did not wrap to top");
  a_rate_reload: assert property (s_fall_run ##0 (cnt_en && st.mode == M2
    && st.cnt == 16'h0001) |=> st.cnt == st.init && st.out_lvl)
    else $error("rate mode did not reload");
  a_gate_forces_out: assert property ((st.mode == M2 || st.mode == M3)
    && !gate_new && !cw_wr |=> st.out_lvl)
    else $error("gate low did not force output high");
  a_rate_low_one: assert property (st.mode == M2 && $fell(st.out_lvl)
    |-> st.cnt == 16'h0001)
    else $error("rate pulse not at count one");
  a_oneshot_start: assert property (st.mode == M1 && st.trig && clk_fall
    && !cw_wr && !cnt_wr |=> !st.out_lvl && st.cnt == st.init)
    else $error("one-shot did not start");
  a_bcd_digits: assert property (s_fall_run ##0 (cnt_en && st.bcd
    && st.cnt[3:0] <= 4'h9 && st.cnt[7:4] <= 4'h9 && st.cnt[11:8] <= 4'h9
    && st.cnt[15:12] <= 4'h9) |=> st.cnt[3:0] <= 4'h9 && st.cnt[7:4] <= 4'h9
    && st.cnt[11:8] <= 4'h9 && st.cnt[15:12] <= 4'h9)
    else $error("decimal digit above nine");

  // Loading, terminal counts, periodic reloads and the edge flag in level modes
  sequence s_fall_load;
    clk_fall && do_load && !cnt_wr && !cw_wr;
  endsequence

  a_load_takes_init: assert property (s_fall_load
    |=> st.cnt == st.init && st.run)
    else $error("load did not take initial count");
  a_level_no_flag: assert property ((st.mode == M0 || st.mode == M4) && !cw_wr
    |=> !st.eflag)
    else $error("edge flag set in a level mode");
  a_sq_reload: assert property (s_fall_run ##0 (cnt_en && gate_new
    && st.mode == M3 && st.cnt == {14'h0000, step})
    |=> st.cnt == st.init && st.out_lvl != $past(st.out_lvl))
    else $error("square wave did not reload and toggle");
  a_rate_high_after: assert property (s_fall_run ##0 (cnt_en && st.mode == M2
    && !st.out_lvl) |=> st.out_lvl)
    else $error("rate pulse longer than one clock");
  a_m0_terminal: assert property (s_fall_run ##0 (cnt_en && st.mode == M0
    && st.cnt == 16'h0001) |=> st.out_lvl && st.cnt == 16'h0000)
    else $error("terminal count did not raise output");
  a_strobe_wrap: assert property (s_fall_run ##0 (cnt_en && st.cnt == 16'h0000
    && (st.mode == M4 || st.mode == M5)) |=> st.out_lvl)
    else $error("strobe did not end at wrap");
  a_oneshot_end: assert property (s_fall_run ##0 (st.mode == M1
    && st.cnt == 16'h0001) |=> st.out_lvl)
    else $error("one-shot did not end at zero");

endmodule : interval_counter
`default_nettype wire

// ===== sim/ictr_pin_model.sv
// Purpose: Model of what drives the counter clock and gate pins
// Assumes: Each level stands long enough for the pin filter
// Notes:   Counter clock stands low between pulses
`timescale 1ns/10ps
`default_nettype none
module ictr_pin_model (
  // System
  input  wire logic sys_clk,
  // Counter pins
  output var  logic ctr_clk,
  output var  logic gate
);
  localparam int HOLD = 6; // Above the three-cycle filter delay

  initial begin
    ctr_clk = 1'b0;
    gate    = 1'b0;
  end

  // Let n edges pass, then move just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  // One counter clock pulse, split so a bench can look between halves
  task automatic rise();
    ctr_clk = 1'b1;
    step(HOLD);
  endtask : rise
  task automatic fall();
    ctr_clk = 1'b0;
    step(HOLD);
  endtask : fall
  task automatic pulse();
    rise();
    fall();
  endtask : pulse

  // Gate level change, or a brief high that ends before the clock rises
  task automatic set_gate(input logic v);
    gate = v;
    step(HOLD);
  endtask : set_gate
  task automatic blip();
    gate = 1'b1;
    step(4);
    gate = 1'b0;
    step(HOLD);
  endtask : blip
endmodule : ictr_pin_model
`default_nettype wire

// ===== sim/tb.sv
// Purpose: Self-checking bench for one interval counter channel
// Assumes: Pins driven by the pin model, strobes just after sys_clk rise
// Notes:   Expected counts follow from the programmed values
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ictr_pkg::*;
  logic        sys_clk, rst_n, cw_wr, cw_bcd, cnt_wr;
  logic [2:0]  cw_mode;
  logic [15:0] cnt_val, count_now;
  logic        ctr_clk, gate, out_level;
  int          n_fail, compares;

  interval_counter u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cw_wr(cw_wr),
    .cw_mode(cw_mode), .cw_bcd(cw_bcd), .cnt_wr(cnt_wr), .cnt_val(cnt_val),
    .ctr_clk(ctr_clk), .gate(gate), .out_level(out_level), .count_now(count_now));
  ictr_pin_model u_pins (.sys_clk(sys_clk), .ctr_clk(ctr_clk), .gate(gate));

  // 10 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // Control word, output level check, then one count word
  task automatic prog(input logic [2:0] m, input logic b, input logic [15:0] v);
    cw_wr = 1'b1; cw_mode = m; cw_bcd = b;
    step(1);
    cw_wr = 1'b0;
    step(1);
    check("out_init", {15'h0, out_level}, {15'h0, (m == 3'd0) ? OUT_INIT_M0 : OUT_INIT});
    cnt_wr = 1'b1; cnt_val = v; // Counts kept at the legal minimum or above
    step(1);
    cnt_wr = 1'b0;
    step(1);
  endtask : prog

  task automatic pc(input logic [15:0] c, input logic o);
    u_pins.pulse();
    check("count", count_now, c);
    check("out", {15'h0, out_level}, {15'h0, o});
  endtask : pc

  // Rate generator: load, decrement, low pulse, reload, gate effects
  task automatic t_mode2();
    u_pins.set_gate(1'b1);
    prog(3'd2, 1'b0, 16'd3);
    pc(16'd3, 1'b1);
    u_pins.rise();
    check("no_rise_dec", count_now, 16'd3);
    u_pins.fall();
    check("fall_dec", count_now, 16'd2);
    pc(16'd1, 1'b0);
    pc(16'd3, 1'b1);
    pc(16'd2, 1'b1);
    pc(16'd1, 1'b0);
    u_pins.set_gate(1'b0);
    check("gate_low_out", {15'h0, out_level}, 16'h1);
    pc(16'd1, 1'b1);
    u_pins.set_gate(1'b1);
    pc(16'd3, 1'b1);
    $display("test mode2 done");
  endtask : t_mode2

  // Zero as largest count, wrap in binary and decimal, digit borrow
  task automatic t_wrap();
    prog(3'd0, 1'b0, 16'h0000);
    pc(16'h0000, 1'b0);
    pc(16'hffff, 1'b0);
    prog(3'd0, 1'b1, 16'h0010);
    pc(16'h0010, 1'b0);
    pc(16'h0009, 1'b0);
    prog(3'd0, 1'b1, 16'h0000);
    pc(16'h0000, 1'b0);
    pc(16'h9999, 1'b0);
    $display("test wrap done");
  endtask : t_wrap

  // Gate level is taken at the clock rise only
  task automatic t_sample();
    prog(3'd4, 1'b0, 16'd5);
    pc(16'd5, 1'b1);
    u_pins.rise();
    u_pins.set_gate(1'b0);
    u_pins.fall();
    check("rise_sampled", count_now, 16'd4);
    pc(16'd4, 1'b1);
    $display("test sample done");
  endtask : t_sample

  // Gate rise triggers a load in every edge mode
  task automatic t_trig();
    logic [2:0] ms[4];
    ms = '{3'd1, 3'd2, 3'd3, 3'd5};
    foreach (ms[i]) begin
      u_pins.set_gate(1'b0);
      prog(ms[i], 1'b0, 16'd6);
      u_pins.set_gate(1'b1);
      pc(16'd6, ms[i] != 3'd1);
    end
    $display("test trigger done");
  endtask : t_trig

  // Short gate pulse is caught once, flag then cleared
  task automatic t_short();
    u_pins.set_gate(1'b0);
    prog(3'd1, 1'b0, 16'd4);
    u_pins.blip();
    pc(16'd4, 1'b0);
    pc(16'd3, 1'b0);
    $display("test short done");
  endtask : t_short

  // Mid-run reset, then square wave through the aliased mode code
  task automatic t_reset();
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    check("rst_cnt", count_now, CNT_RST);
    check("rst_out", {15'h0, out_level}, {15'h0, OUT_INIT});
    step(2);
    u_pins.set_gate(1'b1);
    prog(3'd7, 1'b0, 16'd5);
    pc(16'd5, 1'b1);
    pc(16'd4, 1'b1);
    pc(16'd2, 1'b1);
    pc(16'd5, 1'b0);
    pc(16'd2, 1'b0);
    u_pins.set_gate(1'b0);
    check("sq_gate_low", {15'h0, out_level}, 16'h0001);
    pc(16'd2, 1'b1);
    u_pins.set_gate(1'b1);
    pc(16'd5, 1'b1);
    $display("test reset done");
  endtask : t_reset

  // Terminal count and wrap in modes 0, 4 and 1
  task automatic t_term();
    prog(3'd0, 1'b0, 16'd1);
    pc(16'd1, 1'b0);
    pc(16'd0, 1'b1);
    pc(16'hffff, 1'b1);
    prog(3'd4, 1'b0, 16'd2);
    pc(16'd2, 1'b1);
    pc(16'd1, 1'b1);
    pc(16'd0, 1'b0);
    pc(16'hffff, 1'b1);
    u_pins.set_gate(1'b0);
    prog(3'd1, 1'b0, 16'd2);
    u_pins.set_gate(1'b1);
    pc(16'd2, 1'b0);
    pc(16'd1, 1'b0);
    pc(16'd0, 1'b1);
    pc(16'hffff, 1'b1);
    $display("test terminal done");
  endtask : t_term

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end

  initial begin
    n_fail = 0; compares = 0;
    rst_n = 1'b0; cw_wr = 1'b0; cw_bcd = 1'b0;
    cnt_wr = 1'b0;
    step(5);
    rst_n = 1'b1;
    step(2);
    t_mode2();
    t_wrap();
    t_sample();
    t_trig();
    t_short();
    t_reset();
    t_term();
    conclude();
  end
endmodule : tb
`default_nettype wire
